// ===== ucm_pkg.sv
// Constants for the memory-mapped channel register decode.
`default_nettype none
package ucm_pkg;
   localparam int NUM_CHAN = 8;
   localparam int ADDR_W = 12;
   localparam int CHAN_W = 3;
   localparam int DEPTH = 128;
   localparam int PTR_W = 7;
   localparam int CNT_W = 8;
   localparam logic [11:0] WIN_SIZE = 12'h200;
   localparam logic [8:0] OFF_HOLDING = 9'h000;
   localparam logic [8:0] OFF_IRQ_ENABLE = 9'h001;
   localparam logic [8:0] OFF_IRQ_STATUS = 9'h002;
   localparam logic [8:0] OFF_LINE_CONTROL = 9'h004;
   localparam logic [8:0] OFF_LINE_STATUS = 9'h005;
   localparam logic [8:0] OFF_MODEM_STATUS = 9'h006;
   localparam logic [8:0] OFF_SPECIAL_FUNCTION = 9'h007;
   localparam logic [8:0] OFF_DIVISOR_LOW = 9'h008;
   localparam logic [8:0] OFF_DIVISOR_HIGH = 9'h009;
   localparam logic [8:0] OFF_ENHANCED_FUNCTION = 9'h00A;
   localparam logic [8:0] OFF_TX_IRQ_TRIGGER_LEVEL = 9'h010;
   localparam logic [8:0] OFF_RX_IRQ_TRIGGER_LEVEL = 9'h011;
   localparam logic [8:0] OFF_FLOW_LOW_TRIGGER = 9'h012;
   localparam logic [8:0] OFF_FLOW_HIGH_TRIGGER = 9'h013;
   localparam logic [8:0] OFF_BAUD_PREDIVIDER = 9'h014;
   localparam logic [8:0] OFF_RX_LEVEL_OR_ERROR = 9'h015;
   localparam logic [8:0] OFF_TX_LEVEL_OR_SAMPLE = 9'h016;
   localparam logic [8:0] OFF_GLOBAL_LINE_STATUS = 9'h017;
   localparam logic [8:0] OFF_QUEUE_DATA_FIRST = 9'h100;
   localparam logic [8:0] OFF_QUEUE_DATA_LAST = 9'h17F;
   localparam logic [8:0] OFF_QUEUE_STATUS_FIRST = 9'h180;
   localparam logic [8:0] OFF_QUEUE_STATUS_LAST = 9'h1FF;
   localparam int SFR_RX_COUNT_SEL_BIT = 6;
   localparam int SFR_TX_COUNT_SEL_BIT = 7;
   localparam int FCR_RX_FLUSH_BIT = 1;
   localparam int FCR_TX_FLUSH_BIT = 2;
   localparam int IER_RX_AVAIL_BIT = 0;
   localparam logic [7:0] SAMPLE_CLOCK_MASK = 8'h0F;
   localparam logic [7:0] RST_HOLDING = 8'h00;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] IRQ_STATUS_NONE = 8'hC1;
   localparam logic [7:0] IRQ_STATUS_RX_AVAIL = 8'hC4;
   localparam int LSR_DATA_READY_BIT = 0;
   localparam int LSR_TX_EMPTY_BIT = 5;
   localparam int LSR_TX_IDLE_BIT = 6;
endpackage : ucm_pkg
`default_nettype wire

// ===== ucm_mmio_decode.sv
// Memory-mapped register decode for eight serial channels with receive queues.
// Notes on behaviour
// R1 - Each of the eight channels owns its own 512-byte register window.
// R2 - Channel n window starts at n times 0200h from the base; channel 7 at 0E00h.
// R3 - Low nine address bits select the register; byte registers sit at 00h to 17h.
// R4 - Reading receive holding returns oldest queued byte and pops it; resets to 00h.
// R5 - Host must treat a read from an empty queue as invalid; check line status.
// R6 - Offsets 100h to 17Fh read and write the queue storage directly.
// R7 - Offsets 180h to 1FFh read and write each stored byte's line status.
// R8 - Sample clock is four bits; 0000b means 16; upper bits read zero.
// R9 - Offset 15h is read-only: receive fill count or error counter.
// R10 - Special function bit 6 high selects error counter, low selects receive count.
// R11 - Offset 16h is transmit fill count or sample clock, by select.
// R12 - Special function bit 7 high gives transmit count, low gives sample clock.
// R13 - Transmit interrupt trigger level is read-write at 10h.
// R14 - Receive interrupt trigger level is read-write at 11h.
// R15 - Flow-control low and high thresholds are read-write at 12h and 13h.
// R16 - Global line status is read-write at 17h.
// R17 - Undefined offsets read zero and ignore writes; here 0Bh to 0Fh are stored and read back.
// R18 - At 00h and 02h reads reach receive side, writes reach transmit and queue control.
`default_nettype none
module ucm_mmio_decode
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o,
   output logic mem_rvalid_o,
   input wire logic rx_push_i,
   input wire logic [2:0] rx_chan_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic [7:0] rx_status_i,
   output logic tx_push_o,
   output logic [2:0] tx_chan_o,
   output logic [7:0] tx_byte_o,
   input wire logic [7:0] tx_pop_i
);

   // Storage-backed registers; everything else at 00h..17h is computed or empty.
   function automatic logic is_stored(input logic [8:0] off);
      logic hit;
      hit = 1'b0;
      unique case (off)
         ucm_pkg::OFF_IRQ_ENABLE,
         ucm_pkg::OFF_LINE_CONTROL,
         ucm_pkg::OFF_SPECIAL_FUNCTION,
         ucm_pkg::OFF_DIVISOR_LOW,
         ucm_pkg::OFF_DIVISOR_HIGH,
         9'h00A, 9'h00B, 9'h00C, 9'h00D, 9'h00E, 9'h00F,
         ucm_pkg::OFF_TX_IRQ_TRIGGER_LEVEL,
         ucm_pkg::OFF_RX_IRQ_TRIGGER_LEVEL,
         ucm_pkg::OFF_FLOW_LOW_TRIGGER,
         ucm_pkg::OFF_FLOW_HIGH_TRIGGER,
         ucm_pkg::OFF_BAUD_PREDIVIDER,
         ucm_pkg::OFF_TX_LEVEL_OR_SAMPLE,
         ucm_pkg::OFF_GLOBAL_LINE_STATUS:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
      return hit;
   endfunction : is_stored

   function automatic logic in_data_window(input logic [8:0] off);
      return off >= ucm_pkg::OFF_QUEUE_DATA_FIRST && off <= ucm_pkg::OFF_QUEUE_DATA_LAST;
   endfunction : in_data_window

   function automatic logic in_status_window(input logic [8:0] off);
      return off >= ucm_pkg::OFF_QUEUE_STATUS_FIRST && off <= ucm_pkg::OFF_QUEUE_STATUS_LAST;
   endfunction : in_status_window

   logic [2:0] chan;
   logic [8:0] off;
   logic [6:0] slot;
   logic [7:0] cfg [ucm_pkg::NUM_CHAN][32];
   logic [7:0] rx_data [ucm_pkg::NUM_CHAN][ucm_pkg::DEPTH];
   logic [7:0] rx_stat [ucm_pkg::NUM_CHAN][ucm_pkg::DEPTH];
   logic [6:0] rd_ptr [ucm_pkg::NUM_CHAN];
   logic [6:0] wr_ptr [ucm_pkg::NUM_CHAN];
   logic [7:0] rx_count [ucm_pkg::NUM_CHAN];
   logic [7:0] tx_count [ucm_pkg::NUM_CHAN];
   logic [7:0] err_count [ucm_pkg::NUM_CHAN];
   logic [7:0] holding [ucm_pkg::NUM_CHAN];
   logic [7:0] sel_sfr;
   logic [7:0] next_rdata;

   // The top three address bits pick the channel window, the rest the register.
   assign chan = mem_addr_i[11:9]; // R1 R2
   assign off = mem_addr_i[8:0]; // R3
   assign slot = mem_addr_i[6:0];
   assign sel_sfr = cfg[chan][ucm_pkg::OFF_SPECIAL_FUNCTION[4:0]];

   // Per-channel queue bookkeeping.
   for (genvar ch = 0; ch < ucm_pkg::NUM_CHAN; ch++)
   begin : chan_g
      logic sel;
      logic push;
      logic pop;
      logic rx_flush;
      logic tx_flush;
      logic tx_write;
      // A genvar cannot be part-selected, so the channel number is sized by a cast.
      assign sel = (chan == 3'(ch));
      assign push = rx_push_i && (rx_chan_i == 3'(ch))
         && (rx_count[ch] != 8'(ucm_pkg::DEPTH));
      assign pop = mem_rd_i && sel && (off == ucm_pkg::OFF_HOLDING)
         && (rx_count[ch] != 8'h00); // R4 R18
      assign rx_flush = mem_wr_i && sel && (off == ucm_pkg::OFF_IRQ_STATUS)
         && mem_wdata_i[ucm_pkg::FCR_RX_FLUSH_BIT]; // R18
      assign tx_flush = mem_wr_i && sel && (off == ucm_pkg::OFF_IRQ_STATUS)
         && mem_wdata_i[ucm_pkg::FCR_TX_FLUSH_BIT]; // R18
      // Bytes written while the transmit side is full are dropped, as on a real queue.
      assign tx_write = mem_wr_i && sel && (off == ucm_pkg::OFF_HOLDING)
         && (tx_count[ch] != 8'(ucm_pkg::DEPTH));

      always_ff @(posedge sys_clk_i)
      begin
         if (sys_rst_i || rx_flush)
         begin
            rd_ptr[ch] <= 7'h00;
            wr_ptr[ch] <= 7'h00;
            rx_count[ch] <= 8'h00;
         end
         else
         begin
            if (push)
               wr_ptr[ch] <= wr_ptr[ch] + 7'h01;
            if (pop)
               rd_ptr[ch] <= rd_ptr[ch] + 7'h01; // R4
            // A push in the same cycle as a pop leaves the level unchanged.
            if (push && !pop)
               rx_count[ch] <= rx_count[ch] + 8'h01;
            else if (pop && !push)
               rx_count[ch] <= rx_count[ch] - 8'h01;
         end
      end

      always_ff @(posedge sys_clk_i)
      begin
         if (sys_rst_i || tx_flush)
            tx_count[ch] <= 8'h00;
         else if (tx_write && !tx_pop_i[ch])
            tx_count[ch] <= tx_count[ch] + 8'h01;
         else if (tx_pop_i[ch] && !tx_write && tx_count[ch] != 8'h00)
            tx_count[ch] <= tx_count[ch] - 8'h01;
      end

      // Counts received bytes that arrived with any error flag, saturating.
      always_ff @(posedge sys_clk_i)
      begin
         if (sys_rst_i)
            err_count[ch] <= 8'h00;
         else if (push && rx_status_i != 8'h00 && err_count[ch] != 8'hFF)
            err_count[ch] <= err_count[ch] + 8'h01;
      end

      always_ff @(posedge sys_clk_i)
      begin
         if (sys_rst_i)
            holding[ch] <= ucm_pkg::RST_HOLDING; // R4
         else if (pop)
            holding[ch] <= rx_data[ch][rd_ptr[ch]]; // R4
      end
   end

   // Configuration storage; of the undefined offsets only 0Bh to 0Fh reach it.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         for (int c = 0; c < ucm_pkg::NUM_CHAN; c++)
         begin
            for (int r = 0; r < 32; r++)
            begin
               cfg[c][r] <= ucm_pkg::RST_REG;
            end
         end
      end
      else if (mem_wr_i && off[8:5] == 4'h0 && is_stored(off)) // R13 R14 R15 R16 R17
      begin
         if (off == ucm_pkg::OFF_TX_LEVEL_OR_SAMPLE)
         begin
            // The transmit count is read-only; only the sample clock view takes writes.
            if (!sel_sfr[ucm_pkg::SFR_TX_COUNT_SEL_BIT]) // R12
               cfg[chan][off[4:0]] <= mem_wdata_i & ucm_pkg::SAMPLE_CLOCK_MASK; // R8
         end
         else
            cfg[chan][off[4:0]] <= mem_wdata_i;
      end
   end

   // Queue storage: filled by the receiver, also reachable through the windows.
   always_ff @(posedge sys_clk_i)
   begin
      if (rx_push_i && rx_count[rx_chan_i] != 8'(ucm_pkg::DEPTH))
      begin
         rx_data[rx_chan_i][wr_ptr[rx_chan_i]] <= rx_byte_i;
         rx_stat[rx_chan_i][wr_ptr[rx_chan_i]] <= rx_status_i;
      end
      if (mem_wr_i && in_data_window(off))
         rx_data[chan][slot] <= mem_wdata_i; // R6
      if (mem_wr_i && in_status_window(off))
         rx_stat[chan][slot] <= mem_wdata_i; // R7
   end

   // Read data selection.
   always_comb
   begin
      next_rdata = 8'h00; // R17
      if (in_data_window(off))
         next_rdata = rx_data[chan][slot]; // R6
      else if (in_status_window(off))
         next_rdata = rx_stat[chan][slot]; // R7
      else if (off[8:5] == 4'h0)
      begin
         unique case (off)
            ucm_pkg::OFF_HOLDING:
               // An empty queue returns the last byte taken; the host checks line status.
               next_rdata = (rx_count[chan] != 8'h00) ? rx_data[chan][rd_ptr[chan]]
                  : holding[chan]; // R4 R5 R18
            ucm_pkg::OFF_IRQ_STATUS:
               next_rdata = (rx_count[chan] != 8'h00
                  && cfg[chan][ucm_pkg::OFF_IRQ_ENABLE[4:0]][ucm_pkg::IER_RX_AVAIL_BIT])
                  ? ucm_pkg::IRQ_STATUS_RX_AVAIL : ucm_pkg::IRQ_STATUS_NONE; // R18
            ucm_pkg::OFF_LINE_STATUS:
            begin
               next_rdata[ucm_pkg::LSR_DATA_READY_BIT] = (rx_count[chan] != 8'h00);
               next_rdata[ucm_pkg::LSR_TX_EMPTY_BIT] = (tx_count[chan] == 8'h00);
               next_rdata[ucm_pkg::LSR_TX_IDLE_BIT] = (tx_count[chan] == 8'h00);
            end
            ucm_pkg::OFF_MODEM_STATUS:
               next_rdata = 8'h00;
            ucm_pkg::OFF_DIVISOR_LOW,
            ucm_pkg::OFF_DIVISOR_HIGH:
               next_rdata = 8'h00;
            ucm_pkg::OFF_RX_LEVEL_OR_ERROR:
               next_rdata = sel_sfr[ucm_pkg::SFR_RX_COUNT_SEL_BIT]
                  ? err_count[chan] : rx_count[chan]; // R9 R10
            ucm_pkg::OFF_TX_LEVEL_OR_SAMPLE:
               next_rdata = sel_sfr[ucm_pkg::SFR_TX_COUNT_SEL_BIT] ? tx_count[chan]
                  : (cfg[chan][off[4:0]] & ucm_pkg::SAMPLE_CLOCK_MASK); // R8 R11 R12
            default:
               next_rdata = is_stored(off) ? cfg[chan][off[4:0]] : 8'h00; // R17
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         mem_rdata_o <= 8'h00;
         mem_rvalid_o <= 1'b0;
      end
      else
      begin
         mem_rvalid_o <= mem_rd_i;
         mem_rdata_o <= mem_rd_i ? next_rdata : 8'h00;
      end
   end

   // Transmit bytes leave as a one-cycle strobe toward the serial engine.
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_push_o <= 1'b0;
         tx_chan_o <= 3'h0;
         tx_byte_o <= 8'h00;
      end
      else
      begin
         tx_push_o <= mem_wr_i && off == ucm_pkg::OFF_HOLDING
            && tx_count[chan] != 8'(ucm_pkg::DEPTH); // R18
         if (mem_wr_i && off == ucm_pkg::OFF_HOLDING)
         begin
            tx_chan_o <= chan;
            tx_byte_o <= mem_wdata_i;
         end
      end
   end

endmodule : ucm_mmio_decode
`default_nettype wire

// ===== ucm_mmio_decode_chk.sv
// Port-level checker for the channel register decode.
`default_nettype none
module ucm_mmio_decode_chk
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   input wire logic [7:0] mem_rdata_o,
   input wire logic mem_rvalid_o,
   input wire logic tx_push_o,
   input wire logic [2:0] tx_chan_o,
   input wire logic [7:0] tx_byte_o
);
   logic [8:0] off;
   logic [2:0] chan;
   assign off = mem_addr_i[8:0];
   assign chan = mem_addr_i[11:9];
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_rvalid_after_rd: assert property (mem_rd_i |=> mem_rvalid_o)
      else $error("read not answered one cycle later");
   a_no_stray_rvalid: assert property (!mem_rd_i |=> !mem_rvalid_o)
      else $error("read valid without a read");
   a_rdata_idle_zero: assert property (!mem_rd_i |=> mem_rdata_o == 8'h00)
      else $error("read data not zero when idle");
   a_undef_reads_zero: assert property (mem_rd_i && (off == 9'h003 ||
      (off >= 9'h018 && off <= 9'h0FF)) |=> mem_rdata_o == 8'h00)
      else $error("undefined offset read nonzero");
   a_wo_reads_zero: assert property (mem_rd_i && (off == 9'h008 || off == 9'h009)
      |=> mem_rdata_o == 8'h00)
      else $error("write-only divisor read nonzero");
   a_tx_push_cause: assert property (tx_push_o |-> $past(mem_wr_i) && $past(off) == 9'h000)
      else $error("transmit push without holding write");
   a_tx_push_fields: assert property (tx_push_o |-> tx_byte_o == $past(mem_wdata_i) &&
      tx_chan_o == $past(chan))
      else $error("transmit byte or channel mismatch");
   a_reset_quiet: assert property ($fell(sys_rst_i) |-> !mem_rvalid_o && !tx_push_o &&
      mem_rdata_o == 8'h00)
      else $error("outputs not cleared by reset");
endmodule : ucm_mmio_decode_chk
bind ucm_mmio_decode ucm_mmio_decode_chk u_ucm_mmio_decode_chk (.sys_clk_i, .sys_rst_i,
   .mem_addr_i, .mem_rd_i, .mem_wr_i, .mem_wdata_i, .mem_rdata_o, .mem_rvalid_o,
   .tx_push_o, .tx_chan_o, .tx_byte_o);
`default_nettype wire

// ===== ucm_mmio_decode_tb.sv
// Self-checking testbench for the channel register decode.
`default_nettype none
module ucm_mmio_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] addr = 12'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic rvalid;
   logic push = 1'b0;
   logic [2:0] pchan = 3'h0;
   logic [7:0] pbyte = 8'h00;
   logic [7:0] pstat = 8'h00;
   logic tx_push;
   logic [2:0] tx_chan;
   logic [7:0] tx_byte;
   logic [7:0] pop = 8'h00;
   int n_fail = 0;
   int checks = 0;
   always #20 sys_clk_i = ~sys_clk_i;
   ucm_mmio_decode u_ucm_mmio_decode (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .mem_addr_i(addr), .mem_rd_i(rd), .mem_wr_i(wr), .mem_wdata_i(wdata),
      .mem_rdata_o(rdata), .mem_rvalid_o(rvalid), .rx_push_i(push), .rx_chan_i(pchan),
      .rx_byte_i(pbyte), .rx_status_i(pstat), .tx_push_o(tx_push), .tx_chan_o(tx_chan),
      .tx_byte_o(tx_byte), .tx_pop_i(pop));
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] exp, input logic [7:0] act);
      checks++;
      if (act !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t expected %h got %h", $time, exp, act);
      end
   endtask : chk
   task automatic wr8(input logic [11:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge sys_clk_i);
      wr = 1'b0;
   endtask : wr8
   // The answer is due exactly one cycle after the request, so no wait is needed.
   task automatic rd8(input logic [11:0] a, input logic [7:0] exp);
      @(negedge sys_clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk_i);
      rd = 1'b0;
      chk(8'h01, {7'h00, rvalid});
      chk(exp, rdata);
   endtask : rd8
   task automatic rx(input logic [7:0] b, input logic [7:0] s);
      @(negedge sys_clk_i);
      pchan = 3'h3;
      pbyte = b;
      pstat = s;
      push = 1'b1;
      @(negedge sys_clk_i);
      push = 1'b0;
   endtask : rx
   task automatic t_reset();
      rd8(12'h015, 8'h00);
      rd8(12'h016, 8'h00);
      rd8(12'h000, 8'h00);
      rd8(12'h005, 8'h60);
      $display("reset values done");
   endtask : t_reset
   task automatic t_regs();
      logic [8:0] offs [5] = '{9'h010, 9'h011, 9'h012, 9'h013, 9'h017};
      for (int c = 0; c < 8; c += 7)
         foreach (offs[i])
            wr8({3'(c), offs[i]}, {1'b1, 3'(c), offs[i][3:0]});
      for (int c = 0; c < 8; c += 7)
         foreach (offs[i])
            rd8({3'(c), offs[i]}, {1'b1, 3'(c), offs[i][3:0]});
      $display("channel registers done");
   endtask : t_regs
   task automatic t_rx();
      rx(8'hA5, 8'h00);
      rx(8'h5A, 8'h04);
      rd8(12'h615, 8'h02);
      wr8(12'h607, 8'h40);
      rd8(12'h615, 8'h01);
      wr8(12'h607, 8'h00);
      rd8(12'h700, 8'hA5);
      rd8(12'h781, 8'h04);
      rd8(12'h600, 8'hA5);
      rd8(12'h600, 8'h5A);
      rd8(12'h615, 8'h00);
      rd8(12'h605, 8'h60);
      wr8(12'h705, 8'h3C);
      wr8(12'h785, 8'hC3);
      rd8(12'h705, 8'h3C);
      rd8(12'h785, 8'hC3);
      wr8(12'h603, 8'hFF);
      wr8(12'h618, 8'hFF);
      rd8(12'h603, 8'h00);
      rd8(12'h618, 8'h00);
      wr8(12'h601, 8'h01);
      rx(8'h11, 8'h00);
      rd8(12'h602, 8'hC4);
      wr8(12'h602, 8'h02);
      rd8(12'h615, 8'h00);
      rd8(12'h602, 8'hC1);
      $display("receive side done");
   endtask : t_rx
   task automatic t_tx();
      wr8(12'hA16, 8'hFF);
      rd8(12'hA16, 8'h0F);
      wr8(12'hA07, 8'h80);
      rd8(12'hA16, 8'h00);
      wr8(12'hA00, 8'h77);
      chk(8'h01, {7'h00, tx_push});
      chk(8'h77, tx_byte);
      chk(8'h05, {5'h00, tx_chan});
      rd8(12'hA16, 8'h01);
      rd8(12'hA05, 8'h00);
      @(negedge sys_clk_i);
      pop = 8'h20;
      @(negedge sys_clk_i);
      pop = 8'h00;
      rd8(12'hA16, 8'h00);
      wr8(12'hA16, 8'h55);
      wr8(12'hA07, 8'h00);
      rd8(12'hA16, 8'h0F);
      $display("transmit side done");
   endtask : t_tx
   initial
   begin
      #1000000;
      n_fail++;
      close_out();
   end
   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      t_reset();
      t_regs();
      t_rx();
      t_tx();
      close_out();
   end
endmodule : ucm_mmio_decode_tb
`default_nettype wire
